//--- omw_mode_ctrl.sv
// Operating mode controller: fast/slow clock choice, halt modes, wake-up.
// Assumes oscillator ready levels, the sub clock and Port A come from
// outside the clock domain; halt, interrupt and watchdog come from logic
// on clk_in.

`timescale 1ns/100ps
`default_nettype none

module omw_mode_ctrl (
   input  wire logic                          clk_in,
   input  wire logic                          sys_rst_in,
   input  wire logic [2:0]                    sys_clk_select_in,
   input  wire logic                          hi_osc_sel_in,
   input  wire logic                          lo_osc_source_sel_in,
   input  wire logic                          hi_osc_halt_keep_in,
   input  wire logic                          lo_osc_halt_keep_in,
   input  wire logic                          int_hi_osc_ctrl_in,
   input  wire logic [1:0]                    int_hi_freq_sel_in,
   input  wire logic                          ext_hi_osc_ctrl_in,
   input  wire omw_pkg::omw_osc_rdy_s         osc_ready_in,
   input  wire logic                          sub_clk_in,
   input  wire logic                          halt_in,
   input  wire logic                          clr_wdt_in,
   input  wire logic                          wdt_enable_in,
   input  wire logic                          wdt_overflow_in,
   input  wire logic [omw_pkg::PORTA_W-1:0]   porta_in,
   input  wire logic [omw_pkg::PORTA_W-1:0]   porta_wake_enable_in,
   input  wire logic [omw_pkg::INT_W-1:0]     int_req_in,
   input  wire logic                          int_enable_in,
   input  wire logic                          stack_full_in,
   output var  logic                          sys_tick_out,
   output var  logic                          slow_mode_out,
   output var  logic                          cpu_run_out,
   output var  logic                          hi_osc_run_out,
   output var  logic                          lo_osc_run_out,
   output var  logic                          wdt_clear_out,
   output var  logic                          wdt_run_out,
   output var  logic                          power_down_flag_out,
   output var  logic                          wdt_timeout_flag_out,
   output var  logic                          ext_hi_osc_stable_out,
   output var  logic                          int_hi_osc_stable_out,
   output var  omw_pkg::omw_wake_s            wake_out
);

   // ---------------------------------------------------------------
   // Decoders
   // ---------------------------------------------------------------
   function automatic omw_pkg::omw_state_e halt_target(
      input logic hk, input logic lk);
      unique case ({hk, lk})
         2'b00: halt_target = omw_pkg::st_sleep;
         2'b01: halt_target = omw_pkg::st_idle_sub_only;
         2'b11: halt_target = omw_pkg::st_idle_both_clocks;
         2'b10: halt_target = omw_pkg::st_idle_fast_only;
      endcase
   endfunction : halt_target

   function automatic logic is_running(input omw_pkg::omw_state_e s);
      is_running = (s == omw_pkg::st_fast) || (s == omw_pkg::st_slow) ||
                   (s == omw_pkg::st_slow_wait) ||
                   (s == omw_pkg::st_fast_wait);
   endfunction : is_running

   function automatic logic is_halted(input omw_pkg::omw_state_e s);
      is_halted = (s == omw_pkg::st_sleep) ||
                  (s == omw_pkg::st_idle_sub_only) ||
                  (s == omw_pkg::st_idle_both_clocks) ||
                  (s == omw_pkg::st_idle_fast_only);
   endfunction : is_halted

   function automatic logic hi_runs(input omw_pkg::omw_state_e s,
                                    input logic to_slow);
      hi_runs = (s == omw_pkg::st_fast) || (s == omw_pkg::st_slow_wait) ||
                (s == omw_pkg::st_fast_wait) ||
                (s == omw_pkg::st_idle_both_clocks) ||
                (s == omw_pkg::st_idle_fast_only) ||
                ((s == omw_pkg::st_wake) && !to_slow);
   endfunction : hi_runs

   function automatic logic lo_runs(input omw_pkg::omw_state_e s);
      lo_runs = (s != omw_pkg::st_sleep) &&
                (s != omw_pkg::st_idle_fast_only);
   endfunction : lo_runs

   // ---------------------------------------------------------------
   // Synchronisers
   // ---------------------------------------------------------------
   omw_pkg::omw_osc_rdy_s         rdy_meta;
   omw_pkg::omw_osc_rdy_s         rdy_sync;
   logic                          sub_meta;
   logic                          sub_sync;
   logic                          sub_prev;
   logic [omw_pkg::PORTA_W-1:0]   pa_meta;
   logic [omw_pkg::PORTA_W-1:0]   pa_sync;
   logic [omw_pkg::PORTA_W-1:0]   pa_prev;

   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         rdy_meta <= '0;
         rdy_sync <= '0;
         sub_meta <= 1'b0;
         sub_sync <= 1'b0;
         sub_prev <= 1'b0;
         pa_meta  <= '1;
         pa_sync  <= '1;
         pa_prev  <= '1;
      end else begin
         rdy_meta <= osc_ready_in;
         rdy_sync <= rdy_meta;
         sub_meta <= sub_clk_in;
         sub_sync <= sub_meta;
         sub_prev <= sub_sync;
         pa_meta  <= porta_in;
         pa_sync  <= pa_meta;
         pa_prev  <= pa_sync;
      end
   end

   // ---------------------------------------------------------------
   // Mode state
   // ---------------------------------------------------------------
   omw_pkg::omw_state_e           state;
   omw_pkg::omw_state_e           next_state;
   omw_pkg::omw_wake_kind_e       wake_kind;
   logic                          to_slow;
   logic [omw_pkg::INT_W-1:0]     int_at_entry;
   logic [omw_pkg::PORTA_W-1:0]   pa_fall;
   logic [1:0]                    hi_stab;
   logic                          hi_ok;
   logic                          lo_ok;
   logic                          want_sub;
   logic                          halt_now;
   logic                          wake_pa;
   logic                          wake_int;
   logic                          wake_any;

   genvar p;
   generate
      for (p = 0; p < omw_pkg::PORTA_W; p++) begin : g_pa
         assign pa_fall[p] = pa_prev[p] & ~pa_sync[p] &
                             porta_wake_enable_in[p];
      end
   endgenerate

   assign want_sub = (sys_clk_select_in == omw_pkg::SEL_SUB);
   assign hi_ok    = hi_stab[hi_osc_sel_in];
   assign lo_ok    = lo_osc_source_sel_in ? rdy_sync.ext_lo
                                          : rdy_sync.int_lo;
   assign halt_now = halt_in && is_running(state);
   assign wake_pa  = |pa_fall;
   // Requests pending at entry are masked so they cannot wake.
   assign wake_int = |(int_req_in & ~int_at_entry);
   assign wake_any = is_halted(state) &&
                     (wake_pa || wake_int || wdt_overflow_in);

   always_comb begin
      next_state = state;
      if (halt_now) begin
         next_state = halt_target(hi_osc_halt_keep_in,
                                  lo_osc_halt_keep_in);
      end else begin
         unique case (state)
            omw_pkg::st_fast: begin
               if (want_sub) next_state = omw_pkg::st_slow_wait;
            end
            omw_pkg::st_slow_wait: begin
               if (!want_sub) next_state = omw_pkg::st_fast;
               else if (lo_ok) next_state = omw_pkg::st_slow;
            end
            omw_pkg::st_slow: begin
               if (!want_sub) next_state = omw_pkg::st_fast_wait;
            end
            omw_pkg::st_fast_wait: begin
               if (want_sub) next_state = omw_pkg::st_slow;
               else if (hi_ok) next_state = omw_pkg::st_fast;
            end
            omw_pkg::st_sleep,
            omw_pkg::st_idle_sub_only,
            omw_pkg::st_idle_both_clocks,
            omw_pkg::st_idle_fast_only: begin
               if (wake_any) next_state = omw_pkg::st_wake;
            end
            omw_pkg::st_wake: begin
               if (to_slow ? lo_ok : hi_ok) begin
                  next_state = to_slow ? omw_pkg::st_slow
                                       : omw_pkg::st_fast;
               end
            end
            default: next_state = omw_pkg::st_fast;
         endcase
      end
   end

   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         state <= omw_pkg::st_fast;
      end else begin
         state <= next_state;
      end
   end

   // The wake source and the clock to return to are kept across halt.
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         to_slow      <= 1'b0;
         int_at_entry <= '0;
         wake_kind    <= omw_pkg::wk_porta;
      end else begin
         if (halt_now) begin
            to_slow      <= (state == omw_pkg::st_slow) ||
                            (state == omw_pkg::st_fast_wait);
            int_at_entry <= int_req_in;
         end
         if (wake_any) begin
            if (wdt_overflow_in) wake_kind <= omw_pkg::wk_wdt;
            else if (wake_int) wake_kind <= omw_pkg::wk_int;
            else wake_kind <= omw_pkg::wk_porta;
         end
      end
   end

   // ---------------------------------------------------------------
   // Fast oscillator stability
   // ---------------------------------------------------------------
   logic [1:0]  osc_on;
   logic [1:0]  osc_on_q;
   logic [1:0]  hi_restart;
   logic [1:0]  hi_mode_run;
   logic [1:0]  freq_q;

   assign hi_mode_run[omw_pkg::HI_INT] =
      hi_runs(state, to_slow) && !hi_osc_sel_in;
   assign hi_mode_run[omw_pkg::HI_EXT] =
      hi_runs(state, to_slow) && hi_osc_sel_in;
   assign osc_on[omw_pkg::HI_INT] = int_hi_osc_ctrl_in ||
                                    hi_mode_run[omw_pkg::HI_INT];
   assign osc_on[omw_pkg::HI_EXT] = ext_hi_osc_ctrl_in ||
                                    hi_mode_run[omw_pkg::HI_EXT];
   assign hi_restart[omw_pkg::HI_INT] =
      (osc_on[omw_pkg::HI_INT] && !osc_on_q[omw_pkg::HI_INT]) ||
      (int_hi_freq_sel_in != freq_q);
   assign hi_restart[omw_pkg::HI_EXT] =
      osc_on[omw_pkg::HI_EXT] && !osc_on_q[omw_pkg::HI_EXT];

   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         osc_on_q <= '0;
         freq_q   <= '0;
      end else begin
         osc_on_q <= osc_on;
         freq_q   <= int_hi_freq_sel_in;
      end
   end

   genvar h;
   generate
      for (h = 0; h < 2; h++) begin : g_hi
         logic [omw_pkg::STAB_W-1:0] cnt;
         logic                       rdy;
         assign rdy = (h == omw_pkg::HI_EXT) ? rdy_sync.ext_hi
                                             : rdy_sync.int_hi;
         // The count guards against a ready level left over from
         // before the restart.
         always_ff @(posedge clk_in or posedge sys_rst_in) begin
            if (sys_rst_in) begin
               cnt        <= '0;
               hi_stab[h] <= 1'b0;
            end else if (!osc_on[h] || hi_restart[h] || !rdy) begin
               cnt        <= '0;
               hi_stab[h] <= 1'b0;
            end else if (cnt == omw_pkg::STAB_W'(omw_pkg::HI_STAB_CYCLES)) begin
               hi_stab[h] <= 1'b1;
            end else begin
               cnt <= cnt + 1'b1;
            end
         end
      end
   endgenerate

   assign ext_hi_osc_stable_out = hi_stab[omw_pkg::HI_EXT];
   assign int_hi_osc_stable_out = hi_stab[omw_pkg::HI_INT];

   // ---------------------------------------------------------------
   // System clock enable
   // ---------------------------------------------------------------
   logic [omw_pkg::DIV_W-1:0] div_cnt;
   logic [omw_pkg::DIV_W-1:0] div_mask;
   logic                      fh_tick;
   logic                      use_sub;

   assign div_mask = omw_pkg::DIV_W'((omw_pkg::DIV_ONE
                     << sys_clk_select_in) - omw_pkg::DIV_ONE);
   assign fh_tick  = (div_cnt & div_mask) == div_mask;
   assign use_sub  = (next_state == omw_pkg::st_slow) ||
                     (next_state == omw_pkg::st_fast_wait);

   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         div_cnt      <= '0;
         sys_tick_out <= 1'b0;
      end else begin
         div_cnt <= div_cnt + 1'b1;
         // No tick while halted keeps program and ports frozen.
         if (!is_running(next_state)) sys_tick_out <= 1'b0;
         else if (use_sub) sys_tick_out <= sub_sync && !sub_prev;
         else sys_tick_out <= fh_tick;
      end
   end

   // ---------------------------------------------------------------
   // Mode outputs
   // ---------------------------------------------------------------
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         slow_mode_out  <= 1'b0;
         cpu_run_out    <= 1'b1;
         hi_osc_run_out <= 1'b1;
         lo_osc_run_out <= 1'b1;
      end else begin
         slow_mode_out  <= use_sub;
         cpu_run_out    <= is_running(next_state);
         hi_osc_run_out <= hi_runs(next_state, to_slow || (halt_now &&
                           state == omw_pkg::st_slow));
         lo_osc_run_out <= lo_runs(next_state);
      end
   end

   // ---------------------------------------------------------------
   // Watchdog handshake and status flags
   // ---------------------------------------------------------------
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         wdt_clear_out <= 1'b0;
         wdt_run_out   <= 1'b0;
      end else begin
         wdt_clear_out <= halt_now || clr_wdt_in;
         wdt_run_out   <= wdt_enable_in;
      end
   end

   // Set beats clear when both arrive in one cycle.
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         power_down_flag_out  <= 1'b0;
         wdt_timeout_flag_out <= 1'b0;
      end else begin
         if (halt_now) power_down_flag_out <= 1'b1;
         else if (clr_wdt_in) power_down_flag_out <= 1'b0;
         if (wdt_overflow_in) wdt_timeout_flag_out <= 1'b1;
         else if (halt_now) wdt_timeout_flag_out <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Wake response
   // ---------------------------------------------------------------
   logic wake_done;
   assign wake_done = (state == omw_pkg::st_wake) &&
                      (next_state != omw_pkg::st_wake);

   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         wake_out <= '0;
      end else begin
         wake_out <= '0;
         if (wake_done) begin
            unique case (wake_kind)
               omw_pkg::wk_wdt: wake_out.pc_sp_reset <= 1'b1;
               omw_pkg::wk_int: begin
                  if (int_enable_in && !stack_full_in)
                     wake_out.int_service <= 1'b1;
                  else
                     wake_out.resume <= 1'b1;
               end
               omw_pkg::wk_porta: wake_out.resume <= 1'b1;
               default: wake_out.resume <= 1'b1;
            endcase
         end
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   chk_slow_switch: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      state == omw_pkg::st_slow_wait && want_sub && lo_ok && !halt_in
      |=> state == omw_pkg::st_slow && slow_mode_out)
      else $error("slow switch did not complete");

   chk_sleep_entry: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      halt_now && !hi_osc_halt_keep_in && !lo_osc_halt_keep_in
      |=> !hi_osc_run_out && !lo_osc_run_out && !cpu_run_out)
      else $error("sleep entry left a clock running");

   chk_idle_sub: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      halt_now && !hi_osc_halt_keep_in && lo_osc_halt_keep_in
      |=> !hi_osc_run_out && lo_osc_run_out)
      else $error("idle with sub clock entered wrongly");

   chk_idle_both: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      halt_now && hi_osc_halt_keep_in && lo_osc_halt_keep_in
      |=> hi_osc_run_out && lo_osc_run_out && !cpu_run_out)
      else $error("idle with both clocks entered wrongly");

   chk_idle_fast: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      halt_now && hi_osc_halt_keep_in && !lo_osc_halt_keep_in
      |=> hi_osc_run_out && !lo_osc_run_out)
      else $error("idle with fast clock entered wrongly");

   chk_halt_flags: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      halt_now && !wdt_overflow_in
      |=> power_down_flag_out && !wdt_timeout_flag_out && wdt_clear_out)
      else $error("halt flags wrong");

   chk_pdf_clear: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      clr_wdt_in && !halt_now |=> !power_down_flag_out)
      else $error("power-down flag not cleared");

   chk_stale_int: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      is_halted(state) && !wake_pa && !wdt_overflow_in &&
      ((int_req_in & ~int_at_entry) == '0) |=> $stable(state))
      else $error("stale interrupt woke the device");

   chk_wake_hold: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      state == omw_pkg::st_wake && !(to_slow ? lo_ok : hi_ok)
      |=> !cpu_run_out && !sys_tick_out)
      else $error("resumed before oscillator stable");

   chk_div_gap: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      state == omw_pkg::st_fast && $stable(state) && sys_tick_out &&
      sys_clk_select_in != omw_pkg::SEL_FH &&
      $stable(sys_clk_select_in) |=> !sys_tick_out)
      else $error("divided clock ticked too often");

   chk_int_restart: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      hi_restart[omw_pkg::HI_INT] |=> !int_hi_osc_stable_out)
      else $error("stable flag not cleared on restart");

endmodule : omw_mode_ctrl

`default_nettype wire

//--- omw_pkg.sv
// Constants, state codes and carriers for the operating mode controller.
// Assumes one 40 MHz clock; the fast oscillator rate equals that clock.

`default_nettype none

package omw_pkg;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS   = 25;
   localparam int unsigned HI_STAB_TIME_NS = 2000;
   localparam int unsigned HI_STAB_CYCLES  =
      (HI_STAB_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int          STAB_W          = 8;

   // ---------------------------------------------------------------
   // Field widths and codes
   // ---------------------------------------------------------------
   localparam int          PORTA_W   = 8;
   localparam int          INT_W     = 4;
   localparam int          DIV_W     = 6;
   localparam int          HI_INT    = 0;
   localparam int          HI_EXT    = 1;
   localparam logic [2:0]  SEL_SUB   = 3'h7;
   localparam logic [2:0]  SEL_FH    = 3'h0;
   localparam logic [DIV_W-1:0] DIV_ONE = 6'h01;

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef enum logic [3:0] {
      st_fast,
      st_slow_wait,
      st_slow,
      st_fast_wait,
      st_sleep,
      st_idle_sub_only,
      st_idle_both_clocks,
      st_idle_fast_only,
      st_wake
   } omw_state_e;

   typedef enum logic [1:0] {
      wk_porta,
      wk_int,
      wk_wdt
   } omw_wake_kind_e;

   typedef struct packed {
      logic ext_hi;
      logic int_hi;
      logic ext_lo;
      logic int_lo;
   } omw_osc_rdy_s;

   typedef struct packed {
      logic resume;
      logic int_service;
      logic pc_sp_reset;
   } omw_wake_s;

endpackage : omw_pkg

`default_nettype wire

//--- operating_mode_wakeup_ctrl_test.sv
// Self-checking bench for the operating mode controller.
// Assumes the design's own sync latencies and an 80 cycle stable count.
`timescale 1ns/100ps
`default_nettype none
module operating_mode_wakeup_ctrl_test;
   // ---------------------------------------------------------------
   // Stimulus and observed signals
   // ---------------------------------------------------------------
   logic               clk, rst, halt, clrw, wdov, lsel, hk, lk, ien, sfull;
   logic               sub, tick, slow, run, hrun, lrun, wclr, wrun;
   logic               power_down_flag, tof, xst, ist;
   logic [2:0]         sel;
   logic [7:0]         pa, paw, cnt;
   logic [3:0]         irq;
   logic               hctl;
   logic [1:0]         frq;
   omw_pkg::omw_wake_s wk;
   int                 error_cnt, compares;
   omw_mode_ctrl u_dut (.clk_in(clk), .sys_rst_in(rst),
      .sys_clk_select_in(sel), .hi_osc_sel_in(1'b0),
      .lo_osc_source_sel_in(lsel), .hi_osc_halt_keep_in(hk),
      .lo_osc_halt_keep_in(lk), .int_hi_osc_ctrl_in(hctl),
      .int_hi_freq_sel_in(frq), .ext_hi_osc_ctrl_in(1'b0),
      .osc_ready_in(4'hf), .sub_clk_in(sub), .halt_in(halt),
      .clr_wdt_in(clrw), .wdt_enable_in(1'b1), .wdt_overflow_in(wdov),
      .porta_in(pa), .porta_wake_enable_in(paw), .int_req_in(irq),
      .int_enable_in(ien), .stack_full_in(sfull), .sys_tick_out(tick),
      .slow_mode_out(slow), .cpu_run_out(run), .hi_osc_run_out(hrun),
      .lo_osc_run_out(lrun), .wdt_clear_out(wclr), .wdt_run_out(wrun),
      .power_down_flag_out(power_down_flag), .wdt_timeout_flag_out(tof),
      .ext_hi_osc_stable_out(xst), .int_hi_osc_stable_out(ist),
      .wake_out(wk));
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // The sub clock period is 17 clk periods, so every sub edge lands on a clk edge.
   initial begin
      sub = 1'b0;
      forever #212.5 sub = ~sub;
   end
   // ---------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------
   task automatic cmp(input logic [7:0] g, input logic [7:0] e);
      compares++;
      if (g !== e) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : cmp
   task automatic step(input int n = 1);
      repeat (n) @(posedge clk);
      #1;
   endtask : step
   task automatic halt_go(input logic h, input logic l);
      hk = h;
      lk = l;
      halt = 1'b1;
      step();
      halt = 1'b0;
      cmp({run, hrun, lrun, power_down_flag, tof, wclr, wrun}, {2'b00, h, l, 4'hb});
   endtask : halt_go
   task automatic wait_wake(input logic [2:0] e);
      for (int k = 0; k < 400 && wk === 3'h0; k++) step();
      cmp(8'(wk), {5'h00, e});
      cmp({7'h00, run}, 8'h01);
   endtask : wait_wake
   task automatic tally_and_finish;
      $display("errors=%0d compares=%0d", error_cnt, compares);
      if (error_cnt == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : tally_and_finish
   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   initial begin
      {rst, halt, clrw, wdov, lsel, hk, lk, ien, sfull} = 9'h100;
      {sel, pa, paw, irq, error_cnt, compares} = '0;
      hctl = 1'b1;
      frq = 2'h0;
      pa = 8'hff;
      repeat (2) @(posedge clk);
      #1 rst = 1'b0;
      step(4);
      for (int n = 0; n < 7; n++) begin
         sel = 3'(n);
         step(4);
         cnt = 8'h00;
         repeat (128) begin
            step();
            cnt = cnt + 8'(tick);
         end
         cmp(cnt, 8'(128 >> n));
      end
      // Without the enable held on, the fast oscillator must restart.
      hctl = 1'b0;
      for (int s = 0; s < 2; s++) begin
         lsel = 1'(s);
         sel = 3'h7;
         for (int k = 0; k < 400 && slow !== 1'b1; k++) step();
         cmp({7'h00, slow}, 8'h01);
         sel = 3'h0;
         step(3);
         cmp({5'h00, xst, slow, ist}, 8'h02);
         for (int k = 0; k < 400 && slow !== 1'b0; k++) step();
         for (int k = 0; k < 400 && ist !== 1'b1; k++) step();
         cmp({5'h00, xst, slow, ist}, 8'h01);
      end
      paw = 8'h01;
      halt_go(1'b0, 1'b0);
      step(10);
      pa = 8'hfe;
      wait_wake(3'b100);
      pa = 8'hff;
      clrw = 1'b1;
      step();
      clrw = 1'b0;
      step();
      cmp({7'h00, power_down_flag}, 8'h00);
      for (int i = 1; i < 4; i++) begin
         halt_go(i[1], i[0]);
         step(5);
         wdov = 1'b1;
         step();
         wdov = 1'b0;
         wait_wake(3'b001);
         cmp({7'h00, tof}, 8'h01);
      end
      for (int f = 0; f < 2; f++) begin
         sfull = 1'(f);
         ien = 1'b1;
         irq = 4'h2;
         halt_go(1'b1, 1'b1);
         step(20);
         cmp({4'h0, run, wk}, 8'h00);
         irq = 4'h3;
         wait_wake(f ? 3'b100 : 3'b010);
         irq = 4'h0;
      end
      sel = 3'h7;
      for (int k = 0; k < 400 && slow !== 1'b1; k++) step();
      halt_go(1'b0, 1'b1);
      pa = 8'hfe;
      wait_wake(3'b100);
      cmp({7'h00, slow}, 8'h01);
      pa = 8'hff;
      sel = 3'h0;
      for (int k = 0; k < 400 && ist !== 1'b1; k++) step();
      frq = 2'h1;
      step();
      cmp({7'h00, ist}, 8'h00);
      for (int k = 0; k < 400 && ist !== 1'b1; k++) step();
      cmp({7'h00, ist}, 8'h01);
      tally_and_finish();
   end
   initial begin
      #500000;
      error_cnt++;
      tally_and_finish();
   end
endmodule : operating_mode_wakeup_ctrl_test
`default_nettype wire
